// ===== aur_pkg.sv
// Shared constants and types of the asynchronous serial receiver with wake-up
package aur_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 3;
  localparam logic [2:0] OFF_RX_STATUS = 3'h0;
  localparam logic [2:0] OFF_RX_DATA = 3'h1;
  localparam logic [2:0] OFF_TX_STATUS = 3'h2;
  localparam logic [2:0] OFF_BAUD_CTRL = 3'h3;
  localparam logic [2:0] OFF_DIV_HIGH = 3'h4;
  localparam logic [2:0] OFF_DIV_LOW = 3'h5;
  localparam logic [2:0] OFF_IRQ_CTRL = 3'h6;

  // ----------------------------------------------------------------
  // Receive status/control fields
  // ----------------------------------------------------------------
  localparam int RS_SERIAL_PORT_ENABLE = 7;
  localparam int RS_NINE_BIT_RECEIVE_ENABLE = 6;
  localparam int RS_SINGLE_RECEIVE_ENABLE = 5;
  localparam int RS_CONTINUOUS_RECEIVE_ENABLE = 4;
  localparam int RS_ADDRESS_DETECT_ENABLE = 3;
  localparam int RS_FRAMING_ERROR_FLAG = 2;
  localparam int RS_OVERRUN_FLAG = 1;
  localparam int RS_NINTH_RECEIVED_BIT = 0;
  localparam logic [7:0] RS_WRITE_MASK = 8'hf8;

  // ----------------------------------------------------------------
  // Transmit status/control, baud control and interrupt control fields
  // ----------------------------------------------------------------
  localparam int TS_SYNC_MODE = 4;
  localparam int TS_HIGH_SPEED_BAUD_SELECT = 2;
  localparam int TS_SHIFT_EMPTY = 1;
  localparam int BC_RECEIVER_IDLE_STATUS = 6;
  localparam int BC_RECEIVE_POLARITY_SELECT = 5;
  localparam int BC_WIDE_DIVISOR_SELECT = 3;
  localparam int BC_WAKE_ON_BREAK_ENABLE = 1;
  localparam logic [7:0] BC_WRITE_MASK = 8'h3b;
  localparam int IC_RECEIVE_INTERRUPT_ENABLE = 0;
  localparam int IC_RECEIVE_COMPLETE_FLAG = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_RX_STATUS = 8'h00;
  localparam logic [7:0] RST_TX_STATUS = 8'h00;
  localparam logic [7:0] RST_BAUD_CTRL = 8'h00;
  localparam logic [7:0] RST_DIV = 8'h00;

  // ----------------------------------------------------------------
  // Timing counts
  // ----------------------------------------------------------------
  localparam int OVERSAMPLE = 16;
  localparam logic [3:0] OS_MID = 4'h8;
  localparam logic [3:0] OS_LAST = 4'hf;
  localparam logic [1:0] SLOW_PRESCALE_LAST = 2'h3;
  localparam logic [3:0] LAST_BIT_EIGHT = 4'h7;
  localparam logic [3:0] LAST_BIT_NINE = 4'h8;
  localparam int BUF_DEPTH = 2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic framing_error;
    logic ninth_bit;
    logic [7:0] data;
  } aur_word_s;

  typedef enum logic [3:0] {
    AUR_IDLE = 4'b0001,
    AUR_START = 4'b0010,
    AUR_DATA = 4'b0100,
    AUR_STOP = 4'b1000
  } aur_state_e;

endpackage

// ===== aur_receiver.sv
// Asynchronous serial receiver with two-word buffer and wake-on-break
`timescale 1ns/100ps
module aur_receiver (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [aur_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic serial_receive_pin,
  input wire logic sleep,
  output logic receive_complete_flag,
  output logic receive_irq
);
  import aur_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic maj3(input logic [2:0] s);
    maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] rx_status;
  logic [7:0] tx_status;
  logic [7:0] baud_ctrl;
  logic [7:0] div_high;
  logic [7:0] div_low;
  logic receive_interrupt_enable;
  logic rx_meta;
  logic rx_sync;
  logic rx_prev;
  logic [15:0] brg_cnt;
  logic brg_tick;
  logic [1:0] prescale;
  logic tick16;
  aur_state_e state;
  logic [3:0] os_cnt;
  logic [3:0] bit_cnt;
  logic [2:0] samples;
  logic [8:0] shifter;
  logic word_done;
  aur_word_s word_in;
  aur_word_s buffer [BUF_DEPTH];
  logic rd_ptr;
  logic [1:0] count;
  logic wake_flag;
  logic wake_seen;
  logic rx_line;
  logic serial_port_enable;
  logic nine_bit_receive_enable;
  logic continuous_receive_enable;
  logic address_detect_enable;
  logic overrun_flag;
  logic async_mode;
  logic wake_on_break_enable;
  logic high_speed_baud_select;
  logic wide_divisor_select;
  logic rx_enabled;
  logic [15:0] divisor;
  logic data_read;
  logic word_kept;
  logic pop;
  logic push;
  logic fall_edge;
  logic rise_edge;
  logic wake_monitor;
  logic sample_now;
  aur_word_s head;

  assign serial_port_enable = rx_status[RS_SERIAL_PORT_ENABLE];
  assign nine_bit_receive_enable = rx_status[RS_NINE_BIT_RECEIVE_ENABLE];
  assign continuous_receive_enable = rx_status[RS_CONTINUOUS_RECEIVE_ENABLE];
  assign address_detect_enable = rx_status[RS_ADDRESS_DETECT_ENABLE];
  assign overrun_flag = rx_status[RS_OVERRUN_FLAG];
  assign async_mode = ~tx_status[TS_SYNC_MODE];
  assign wake_on_break_enable = baud_ctrl[BC_WAKE_ON_BREAK_ENABLE];
  assign high_speed_baud_select = tx_status[TS_HIGH_SPEED_BAUD_SELECT];
  assign wide_divisor_select = baud_ctrl[BC_WIDE_DIVISOR_SELECT];
  assign head = buffer[rd_ptr];

  // Receiver runs only in async mode, enabled, awake, not waiting for wake
  assign rx_enabled = serial_port_enable & async_mode & continuous_receive_enable
    & ~sleep & ~wake_on_break_enable & ~overrun_flag;

  // ----------------------------------------------------------------
  // Pin synchroniser and polarity
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
      rx_prev <= 1'b1;
    end else if (clk_en) begin
      rx_meta <= serial_receive_pin;
      rx_sync <= rx_meta;
      rx_prev <= rx_line;
    end
  end

  assign rx_line = rx_sync ^ baud_ctrl[BC_RECEIVE_POLARITY_SELECT];
  assign fall_edge = rx_prev & ~rx_line;
  assign rise_edge = ~rx_prev & rx_line;

  // ----------------------------------------------------------------
  // Baud generator
  // ----------------------------------------------------------------
  assign divisor = wide_divisor_select ? {div_high, div_low} : {8'h00, div_low};

  always_ff @(posedge clk) begin
    if (reset) begin
      brg_cnt <= 16'h0000;
      brg_tick <= 1'b0;
    end else if (clk_en) begin
      brg_tick <= 1'b0;
      if (!serial_port_enable || sleep) begin
        brg_cnt <= divisor;
      end else if (brg_cnt == 16'h0000) begin
        brg_cnt <= divisor;
        brg_tick <= 1'b1;
      end else begin
        brg_cnt <= brg_cnt - 16'h0001;
      end
    end
  end

  // Slow mode gives x64 ticks; divide by four down to the x16 sample rate
  always_ff @(posedge clk) begin
    if (reset) begin
      prescale <= 2'h0;
      tick16 <= 1'b0;
    end else if (clk_en) begin
      tick16 <= 1'b0;
      if (brg_tick) begin
        if (high_speed_baud_select || wide_divisor_select) begin
          tick16 <= 1'b1;
        end else begin
          prescale <= prescale + 2'h1;
          tick16 <= (prescale == SLOW_PRESCALE_LAST);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Data recovery and receive shifter
  // ----------------------------------------------------------------
  assign sample_now = tick16 && (os_cnt == OS_MID);

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= AUR_IDLE;
      os_cnt <= 4'h0;
      bit_cnt <= 4'h0;
      samples <= 3'h7;
      shifter <= 9'h000;
      word_done <= 1'b0;
      word_in <= '0;
    end else if (clk_en) begin
      word_done <= 1'b0;
      if (tick16) begin
        samples <= {samples[1:0], rx_line};
      end
      if (!rx_enabled) begin
        state <= AUR_IDLE;
        os_cnt <= 4'h0;
      end else begin
        unique case (state)
          AUR_IDLE: begin
            os_cnt <= 4'h0;
            if (tick16 && !rx_line) begin
              state <= AUR_START;
            end
          end
          AUR_START: begin
            if (tick16) begin
              os_cnt <= os_cnt + 4'h1;
              if (sample_now && maj3({samples[1:0], rx_line})) begin
                state <= AUR_IDLE;
              end else if (os_cnt == OS_LAST) begin
                state <= AUR_DATA;
                bit_cnt <= 4'h0;
              end
            end
          end
          AUR_DATA: begin
            if (tick16) begin
              os_cnt <= os_cnt + 4'h1;
              if (sample_now) begin
                shifter <= {maj3({samples[1:0], rx_line}), shifter[8:1]};
              end
              if (os_cnt == OS_LAST) begin
                bit_cnt <= bit_cnt + 4'h1;
                if (bit_cnt == (nine_bit_receive_enable ? LAST_BIT_NINE
                                                        : LAST_BIT_EIGHT)) begin
                  state <= AUR_STOP;
                end
              end
            end
          end
          AUR_STOP: begin
            if (tick16) begin
              os_cnt <= os_cnt + 4'h1;
              if (sample_now) begin
                word_done <= 1'b1;
                word_in.framing_error <= ~maj3({samples[1:0], rx_line});
                word_in.ninth_bit <= nine_bit_receive_enable & shifter[8];
                word_in.data <= nine_bit_receive_enable ? shifter[7:0] : shifter[8:1];
                state <= AUR_IDLE;
              end
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Two-word receive buffer
  // ----------------------------------------------------------------
  assign data_read = reg_read && hit(reg_addr, OFF_RX_DATA);
  assign pop = data_read && (count != 2'h0);
  assign word_kept = word_done && !overrun_flag
    && !(address_detect_enable && nine_bit_receive_enable && !word_in.ninth_bit);
  assign push = word_kept && ((count != 2'h2) || pop);

  always_ff @(posedge clk) begin
    if (reset) begin
      rd_ptr <= 1'b0;
      count <= 2'h0;
      buffer[0] <= '0;
      buffer[1] <= '0;
    end else if (clk_en) begin
      if (push) begin
        buffer[rd_ptr ^ count[0]] <= word_in;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

  // ----------------------------------------------------------------
  // Wake-on-break monitor
  // ----------------------------------------------------------------
  assign wake_monitor = wake_on_break_enable && serial_port_enable && async_mode;

  always_ff @(posedge clk) begin
    if (reset) begin
      wake_flag <= 1'b0;
      wake_seen <= 1'b0;
    end else if (clk_en) begin
      if (wake_monitor && fall_edge && !wake_seen) begin
        wake_flag <= 1'b1;
        wake_seen <= 1'b1;
      end else begin
        if (data_read) begin
          wake_flag <= 1'b0;
        end
        if (!wake_monitor || rise_edge) begin
          wake_seen <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Register writes and hardware-owned status bits
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      rx_status <= RST_RX_STATUS;
      tx_status <= RST_TX_STATUS;
      baud_ctrl <= RST_BAUD_CTRL;
      div_high <= RST_DIV;
      div_low <= RST_DIV;
      receive_interrupt_enable <= 1'b0;
    end else if (clk_en) begin
      if (reg_write && hit(reg_addr, OFF_RX_STATUS)) begin
        rx_status <= (reg_wdata & RS_WRITE_MASK) | (rx_status & ~RS_WRITE_MASK);
      end
      if (!continuous_receive_enable
          || (reg_write && hit(reg_addr, OFF_RX_STATUS)
              && !reg_wdata[RS_CONTINUOUS_RECEIVE_ENABLE])) begin
        rx_status[RS_OVERRUN_FLAG] <= 1'b0;
      end else if (word_kept && (count == 2'h2) && !pop) begin
        rx_status[RS_OVERRUN_FLAG] <= 1'b1;
      end
      if (reg_write && hit(reg_addr, OFF_TX_STATUS)) begin
        tx_status <= reg_wdata;
      end
      if (reg_write && hit(reg_addr, OFF_BAUD_CTRL)) begin
        baud_ctrl <= reg_wdata & BC_WRITE_MASK;
      end else if (wake_seen && wake_monitor && rise_edge) begin
        baud_ctrl[BC_WAKE_ON_BREAK_ENABLE] <= 1'b0;
      end
      if (reg_write && hit(reg_addr, OFF_DIV_HIGH)) begin
        div_high <= reg_wdata;
      end
      if (reg_write && hit(reg_addr, OFF_DIV_LOW)) begin
        div_low <= reg_wdata;
      end
      if (reg_write && hit(reg_addr, OFF_IRQ_CTRL)) begin
        receive_interrupt_enable <= reg_wdata[IC_RECEIVE_INTERRUPT_ENABLE];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read port: data stands only in the cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      reg_rdata <= 8'h00;
      if (reg_read) begin
        unique case (reg_addr)
          OFF_RX_STATUS: begin
            reg_rdata <= rx_status;
            reg_rdata[RS_FRAMING_ERROR_FLAG] <= (count != 2'h0) & head.framing_error;
            reg_rdata[RS_NINTH_RECEIVED_BIT] <= head.ninth_bit;
          end
          OFF_RX_DATA: reg_rdata <= head.data;
          OFF_TX_STATUS: begin
            reg_rdata <= tx_status;
            reg_rdata[TS_SHIFT_EMPTY] <= 1'b1;
          end
          OFF_BAUD_CTRL: begin
            reg_rdata <= baud_ctrl;
            reg_rdata[BC_RECEIVER_IDLE_STATUS] <= (state == AUR_IDLE);
          end
          OFF_DIV_HIGH: reg_rdata <= div_high;
          OFF_DIV_LOW: reg_rdata <= div_low;
          OFF_IRQ_CTRL: begin
            reg_rdata[IC_RECEIVE_INTERRUPT_ENABLE] <= receive_interrupt_enable;
            reg_rdata[IC_RECEIVE_COMPLETE_FLAG] <= receive_complete_flag;
          end
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive flag and interrupt request
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      receive_complete_flag <= 1'b0;
      receive_irq <= 1'b0;
    end else if (clk_en) begin
      receive_complete_flag <= (count != 2'h0) | wake_flag;
      receive_irq <= ((count != 2'h0) | wake_flag) & receive_interrupt_enable;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_irq_gated: assert property (
    @(posedge clk) disable iff (reset)
    receive_irq |-> receive_complete_flag && $past(receive_interrupt_enable))
    else $error("interrupt raised without flag or enable");

  a_overrun_third: assert property (
    @(posedge clk) disable iff (reset)
    clk_en && word_kept && count == 2'h2 && !pop && continuous_receive_enable
    |=> overrun_flag && count == 2'h2)
    else $error("third word did not set overrun");

  a_continuous_receive_enable_clears: assert property (
    @(posedge clk) disable iff (reset)
    clk_en && !continuous_receive_enable |=> !overrun_flag)
    else $error("overrun kept while continuous receive off");

  a_wake_idle: assert property (
    @(posedge clk) disable iff (reset)
    clk_en && wake_on_break_enable |=> state == AUR_IDLE && !word_done)
    else $error("receiver active while wake enabled");

  a_wake_flag_set: assert property (
    @(posedge clk) disable iff (reset)
    clk_en && wake_monitor && fall_edge && !wake_seen
    |=> wake_flag ##1 (receive_complete_flag || !clk_en))
    else $error("wake edge did not raise receive flag");

  a_wue_autoclr: assert property (
    @(posedge clk) disable iff (reset)
    clk_en && wake_seen && wake_monitor && rise_edge && !reg_write |=> !wake_on_break_enable)
    else $error("wake enable not cleared on rising edge");

  a_addr_filter: assert property (
    @(posedge clk) disable iff (reset)
    clk_en && word_done && address_detect_enable && nine_bit_receive_enable
    && !word_in.ninth_bit && !pop |=> $stable(count))
    else $error("address filter let a data character in");

  a_sleep_idle: assert property (
    @(posedge clk) disable iff (reset)
    clk_en && sleep |=> state == AUR_IDLE && !brg_tick)
    else $error("receiver ran during sleep");

  a_no_wake_sync: assert property (
    @(posedge clk) disable iff (reset)
    clk_en && !async_mode && !wake_seen |=> !wake_seen)
    else $error("wake armed in synchronous mode");

  a_wake_read_clr: assert property (
    @(posedge clk) disable iff (reset)
    clk_en && data_read && !(wake_monitor && fall_edge && !wake_seen) |=> !wake_flag)
    else $error("data read did not clear wake flag");

endmodule

// ===== aur_line_model.sv
// Remote serial transmitter model that drives the receive line
`timescale 1ns/100ps
module aur_line_model #(
  parameter int BIT_CLKS = 32
) (
  input wire logic clk,
  input wire logic send,
  input wire logic [8:0] word,
  input wire logic nine,
  input wire logic stop_bit,
  output logic line,
  output logic busy
);
  logic [10:0] frame;
  int nbits;

  initial begin
    line = 1'b1;
    busy = 1'b0;
  end

  // ----------------------------------------------------------------
  // Frame sender: start bit, data, stop bit, then idle high
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (send && !busy) begin
      busy <= 1'b1;
      frame = nine ? {stop_bit, word, 1'b0} : {1'b1, stop_bit, word[7:0], 1'b0};
      nbits = nine ? 11 : 10;
      for (int i = 0; i < nbits; i++) begin
        line <= frame[i];
        repeat (BIT_CLKS) @(posedge clk);
      end
      line <= 1'b1;
      busy <= 1'b0;
    end
  end
endmodule

// ===== aur_receiver_tb.sv
// Self-checking bench of the serial receiver with wake-on-break
`timescale 1ns/100ps
module aur_receiver_tb;
  import aur_pkg::*;
  localparam logic [7:0] DIV = 8'h01;
  localparam logic [7:0] ON = 8'h90;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata;
  logic sleep = 1'b0;
  logic brk = 1'b0;
  logic receive_complete_flag;
  logic receive_irq;
  logic send = 1'b0;
  logic [8:0] word = 9'h000;
  logic nine = 1'b0;
  logic stop_bit = 1'b1;
  logic line;
  logic busy;
  logic pin;
  logic [7:0] v;
  logic [7:0] w [0:4];
  int num_errors = 0;
  int checks_done = 0;
  int seed = 32'h675d;
  int cyc = 0;

  // Break is the line held low on top of the transmitter
  assign pin = line & !brk;

  aur_receiver DUT (
    .clk(clk),
    .reset(reset),
    .clk_en(1'b1),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .reg_rdata(reg_rdata),
    .serial_receive_pin(pin),
    .sleep(sleep),
    .receive_complete_flag(receive_complete_flag),
    .receive_irq(receive_irq)
  );

  aur_line_model #(.BIT_CLKS(16 * (int'(DIV) + 1))) line_tx (
    .clk(clk),
    .send(send),
    .word(word),
    .nine(nine),
    .stop_bit(stop_bit),
    .line(line),
    .busy(busy)
  );

  initial begin
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    if (num_errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      report_and_stop;
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic tx(input logic [8:0] d, input logic n, input logic s);
    @(posedge clk);
    word <= d;
    nine <= n;
    stop_bit <= s;
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    #1;
    while (busy) begin
      @(posedge clk);
      #1;
    end
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic flags(input logic [1:0] e);
    @(posedge clk);
    #1 chk({6'h0, receive_irq, receive_complete_flag}, {6'h0, e});
  endtask

  function automatic logic [7:0] st(input logic [7:0] c, input logic fe, input logic ov,
                                    input logic n9);
    st = c;
    st[RS_FRAMING_ERROR_FLAG] = fe;
    st[RS_OVERRUN_FLAG] = ov;
    st[RS_NINTH_RECEIVED_BIT] = n9;
  endfunction

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    for (int a = 0; a < 8; a++) begin
      rd(a[2:0], v);
      if (a == OFF_BAUD_CTRL)
        v[BC_RECEIVER_IDLE_STATUS] = 1'b0;
      chk(v, (a == OFF_TX_STATUS) ? 8'h02 : 8'h00);
    end
    wr(3'h7, 8'hff);
    rd(3'h7, v);
    chk(v, 8'h00);
    wr(OFF_RX_STATUS, 8'hff);
    rd(OFF_RX_STATUS, v);
    chk(v, RS_WRITE_MASK);
    wr(OFF_DIV_LOW, DIV);
    wr(OFF_TX_STATUS, 8'h04);
    wr(OFF_IRQ_CTRL, 8'h01);
    wr(OFF_RX_STATUS, ON);
    w[0] = 8'h00;
    w[1] = 8'hff;
    for (int i = 0; i < 5; i++) begin
      if (i > 1)
        w[i] = 8'($random(seed));
      tx({1'b0, w[i]}, 1'b0, 1'b1);
      flags(2'h3);
      rd(OFF_RX_STATUS, v);
      chk(v, st(ON, 1'b0, 1'b0, 1'b0));
      rd(OFF_RX_DATA, v);
      chk(v, w[i]);
      flags(2'h0);
    end
    for (int i = 0; i < 3; i++) begin
      w[i] = 8'($random(seed));
      tx({1'b0, w[i]}, 1'b0, 1'b1);
    end
    rd(OFF_RX_STATUS, v);
    chk(v, st(ON, 1'b0, 1'b1, 1'b0));
    wr(OFF_IRQ_CTRL, 8'h00);
    flags(2'h1);
    wr(OFF_IRQ_CTRL, 8'h01);
    tx(9'h0aa, 1'b0, 1'b1);
    for (int i = 0; i < 2; i++) begin
      rd(OFF_RX_DATA, v);
      chk(v, w[i]);
    end
    flags(2'h0);
    wr(OFF_RX_STATUS, 8'h80);
    rd(OFF_RX_STATUS, v);
    chk(v, 8'h80);
    tx(9'h055, 1'b0, 1'b1);
    flags(2'h0);
    wr(OFF_RX_STATUS, ON);
    tx(9'h03c, 1'b0, 1'b0);
    rd(OFF_RX_STATUS, v);
    chk(v, st(ON, 1'b1, 1'b0, 1'b0));
    rd(OFF_RX_DATA, v);
    chk(v, 8'h3c);
    wr(OFF_RX_STATUS, 8'hd0);
    tx(9'h1a5, 1'b1, 1'b1);
    rd(OFF_RX_STATUS, v);
    chk(v, st(8'hd0, 1'b0, 1'b0, 1'b1));
    rd(OFF_RX_DATA, v);
    chk(v, 8'ha5);
    wr(OFF_RX_STATUS, 8'hc0);
    wr(OFF_RX_STATUS, 8'hd8);
    tx(9'h033, 1'b1, 1'b1);
    flags(2'h0);
    tx(9'h1c3, 1'b1, 1'b1);
    rd(OFF_RX_STATUS, v);
    chk(v, st(8'hd8, 1'b0, 1'b0, 1'b1));
    rd(OFF_RX_DATA, v);
    chk(v, 8'hc3);
    wr(OFF_RX_STATUS, ON);
    wr(OFF_TX_STATUS, 8'h00);
    wr(OFF_BAUD_CTRL, 8'h08);
    wr(OFF_DIV_HIGH, 8'h00);
    tx(9'h05a, 1'b0, 1'b1);
    rd(OFF_RX_DATA, v);
    chk(v, 8'h5a);
    @(posedge clk);
    sleep <= 1'b1;
    tx(9'h066, 1'b0, 1'b1);
    flags(2'h0);
    sleep <= 1'b0;
    wr(OFF_BAUD_CTRL, 8'h02);
    @(posedge clk);
    brk <= 1'b1;
    repeat (8) @(posedge clk);
    flags(2'h3);
    rd(OFF_BAUD_CTRL, v);
    chk(v & 8'h02, 8'h02);
    @(posedge clk);
    brk <= 1'b0;
    repeat (6) @(posedge clk);
    rd(OFF_BAUD_CTRL, v);
    chk(v & 8'h02, 8'h00);
    rd(OFF_RX_DATA, v);
    flags(2'h0);
    wr(OFF_TX_STATUS, 8'h14);
    wr(OFF_BAUD_CTRL, 8'h02);
    @(posedge clk);
    brk <= 1'b1;
    repeat (6) @(posedge clk);
    flags(2'h0);
    report_and_stop;
  end
endmodule
